// file: core/siwm_core.sv
`timescale 1ns/10ps
// Contract
// - Two-wire stop condition sets stop flag.
// - Stop flag clears by one; no interrupt.
// - Collision reads one when MSB differs pin.
// - Collision only meaningful in two-wire mode.
// - Counter readable in status, writes load it.
// - Counter increments from selected clock source.
// - External select plus strobe bit: toggle counts.
// - Wire mode off still counts external clock.
// - Start enable lets start flag interrupt.
// - Wrap enable lets wrap flag interrupt.
// - Wire mode changes outputs only, not inputs.
// - Mode zero: outputs, hold, detector disabled.
// - Three-wire: serial output replaces port bit.
// - Three-wire: input and clock stay ordinary.
// - Two-wire: open collector, enabled by direction.
// - SDA low when MSB or port zero.
// - SCL low when port zero or held.
// - Start holds SCL until flag cleared.
// - Two-wire disables pull-ups, inputs unaffected.
// - Mode three: wrap holds SCL until cleared.
// - Wrap flag sets on 15 to 0.
// - Two-wire start sets start flag.
module siwm_core
    import siwm_pkg::*;
(
    // Clock and reset.
    input wire logic I_MCLK,
    input wire logic I_RSTN,
    // Register port.
    input wire logic [1:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    // Neighbouring logic on the same clock.
    input wire logic I_TIMER_MATCH,
    input wire logic I_GLOBAL_IE,
    input wire logic I_SHIFT_MSB,
    // Data line (serial_in_pin / SDA).
    input wire logic I_SDA_PIN,
    output logic O_SDA_OUT,
    output logic O_SDA_OE,
    output logic O_SDA_PU,
    // Clock line (serial_clock_pin / SCL).
    input wire logic I_SCL_PIN,
    output logic O_SCL_OUT,
    output logic O_SCL_OE,
    output logic O_SCL_PU,
    // Three-wire data output pin.
    output logic O_DO_OUT,
    output logic O_DO_OE,
    output logic O_DO_PU,
    // Interrupt requests.
    output logic O_START_IRQ,
    output logic O_WRAP_IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // Storage.

    logic [5:0] ctrl_r;
    logic soft_strobe_bit_r;
    logic [7:0] pins_r;
    logic [3:0] edge_count_value_r;
    logic start_seen_flag_r;
    logic wrap_flag_r;
    logic stop_seen_flag_r;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and line detectors.

    logic [1:0] line_s;
    wire sda_s = line_s[0];
    wire scl_s = line_s[1];
    logic det_start;
    logic det_stop;
    logic scl_edge;
    logic two_wire;

    siwm_sync #(.W(2)) u_sync (
        .i_clk(I_MCLK),
        .i_rst_n(I_RSTN),
        .i_async({I_SCL_PIN, I_SDA_PIN}),
        .o_sync(line_s)
    );

    siwm_line_det u_det (
        .i_clk(I_MCLK),
        .i_rst_n(I_RSTN),
        .i_sda(sda_s),
        .i_scl(scl_s),
        .i_enable(two_wire),
        .o_start(det_start),
        .o_stop(det_stop),
        .o_scl_edge(scl_edge)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode.

    wire wr_status = I_WR & (I_ADDR == SIWM_ADDR_STATUS);
    wire wr_ctrl = I_WR & (I_ADDR == SIWM_ADDR_CONTROL);
    wire wr_pins = I_WR & (I_ADDR == SIWM_ADDR_PINS);

    wire start_irq_enable = ctrl_r[CT_SIE-2];
    wire wrap_irq_enable = ctrl_r[CT_OIE-2];
    siwm_wire_t wire_mode_select;
    siwm_csel_t clock_source_select;
    assign wire_mode_select = siwm_wire_t'(ctrl_r[CT_WM_LO-1 -: 2]);
    assign clock_source_select = siwm_csel_t'(ctrl_r[CT_CS_LO-1 -: 2]);

    assign two_wire = wire_mode_select[1];
    wire three_wire = (wire_mode_select == WM_THREE);
    wire hold_mode = (wire_mode_select == WM_TWO_HOLD);
    wire ext_clock = clock_source_select[1];

    wire port_do = pins_r[PN_DO];
    wire port_sda = pins_r[PN_SDA];
    wire port_scl = pins_r[PN_SCL];
    wire dir_do = pins_r[PN_DIR_LO+PN_DO];
    wire dir_sda = pins_r[PN_DIR_LO+PN_SDA];
    wire dir_scl = pins_r[PN_DIR_LO+PN_SCL];

    ////////////////////////////////////////////////////////////////////////
    // Counter clock selection.

    wire soft_tick = (clock_source_select == CS_SOFT) & wr_ctrl & I_WDATA[CT_CLK];
    wire timer_tick = (clock_source_select == CS_TIMER) & I_TIMER_MATCH;
    // External clocking reads the synchronised pin in every wire mode.
    wire ext_tick = ext_clock & ~soft_strobe_bit_r & scl_edge;
    wire toggle_tick = ext_clock & soft_strobe_bit_r & wr_ctrl & I_WDATA[CT_TC];
    wire cnt_tick = soft_tick | timer_tick | ext_tick | toggle_tick;

    // A counter write in the same cycle as a tick wins and no wrap occurs.
    wire wrap_evt = cnt_tick & ~wr_status & (edge_count_value_r == CNT_MAX);
    wire [3:0] cnt_nxt = wr_status ? I_WDATA[3:0] :
        cnt_tick ? 4'(edge_count_value_r + 4'h1) : edge_count_value_r;

    ////////////////////////////////////////////////////////////////////////
    // Flags: a new event in the clearing cycle keeps the flag set.

    wire clr_start = wr_status & I_WDATA[ST_START];
    wire clr_wrap = wr_status & I_WDATA[ST_WRAP];
    wire clr_stop = wr_status & I_WDATA[ST_STOP];
    wire start_nxt = det_start | (start_seen_flag_r & ~clr_start);
    wire wrap_nxt = wrap_evt | (wrap_flag_r & ~clr_wrap);
    wire stop_nxt = det_stop | (stop_seen_flag_r & ~clr_stop);

    // Collision compares the shift MSB with the sensed line; outside the
    // two-wire modes the value is produced but carries no meaning.
    wire drive_collision_flag = sda_s ^ I_SHIFT_MSB;

    ////////////////////////////////////////////////////////////////////////
    // Pin drive.

    wire start_hold = two_wire & start_seen_flag_r;
    wire wrap_hold = hold_mode & wrap_flag_r;
    wire pins_toggle = wr_ctrl & I_WDATA[CT_TC];

    // Open-collector lines only ever drive low; the enable is the pull-down.
    wire sda_oe_nxt = two_wire ? (dir_sda & (~I_SHIFT_MSB | ~port_sda))
                               : dir_sda;
    wire sda_out_nxt = two_wire ? 1'b0 : port_sda;
    wire sda_pu_nxt = ~two_wire & ~dir_sda & port_sda;
    wire scl_oe_nxt = two_wire ? (dir_scl & (~port_scl | start_hold | wrap_hold))
                               : dir_scl;
    wire scl_out_nxt = two_wire ? 1'b0 : port_scl;
    wire scl_pu_nxt = ~two_wire & ~dir_scl & port_scl;
    wire do_out_nxt = three_wire ? I_SHIFT_MSB : port_do;
    wire do_pu_nxt = ~dir_do & port_do;

    ////////////////////////////////////////////////////////////////////////
    // Read path; unmapped indices read zero.

    wire [7:0] status_rd = {start_seen_flag_r, wrap_flag_r, stop_seen_flag_r,
                            drive_collision_flag, edge_count_value_r};
    // Strobe bits are write-only actions and always read back as zero.
    wire [7:0] ctrl_rd = {ctrl_r, 2'b00};
    wire [7:0] rd_mux = (I_ADDR == SIWM_ADDR_STATUS) ? status_rd :
                        (I_ADDR == SIWM_ADDR_CONTROL) ? ctrl_rd :
                        (I_ADDR == SIWM_ADDR_PINS) ? pins_r : RDATA_RST;
    wire [7:0] rdata_nxt = I_RD ? rd_mux : RDATA_RST;

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ctrl_r <= CONTROL_RST;
            soft_strobe_bit_r <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_r <= I_WDATA[7:2];
            soft_strobe_bit_r <= I_WDATA[CT_CLK];
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            pins_r <= PINS_RST;
        end else if (wr_pins) begin
            pins_r <= I_WDATA;
        end else if (pins_toggle) begin
            pins_r[PN_SCL] <= ~port_scl;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            edge_count_value_r <= CNT_RST;
            start_seen_flag_r <= 1'b0;
            wrap_flag_r <= 1'b0;
            stop_seen_flag_r <= 1'b0;
        end else begin
            edge_count_value_r <= cnt_nxt;
            start_seen_flag_r <= start_nxt;
            wrap_flag_r <= wrap_nxt;
            stop_seen_flag_r <= stop_nxt;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_SDA_OUT <= 1'b0;
            O_SDA_OE <= 1'b0;
            O_SDA_PU <= 1'b0;
            O_SCL_OUT <= 1'b0;
            O_SCL_OE <= 1'b0;
            O_SCL_PU <= 1'b0;
        end else begin
            O_SDA_OUT <= sda_out_nxt;
            O_SDA_OE <= sda_oe_nxt;
            O_SDA_PU <= sda_pu_nxt;
            O_SCL_OUT <= scl_out_nxt;
            O_SCL_OE <= scl_oe_nxt;
            O_SCL_PU <= scl_pu_nxt;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_DO_OUT <= 1'b0;
            O_DO_OE <= 1'b0;
            O_DO_PU <= 1'b0;
            O_RDATA <= RDATA_RST;
        end else begin
            O_DO_OUT <= do_out_nxt;
            O_DO_OE <= dir_do;
            O_DO_PU <= do_pu_nxt;
            O_RDATA <= rdata_nxt;
        end
    end

    // The stop flag has no request path at all.
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_START_IRQ <= 1'b0;
            O_WRAP_IRQ <= 1'b0;
        end else begin
            O_START_IRQ <= start_seen_flag_r & start_irq_enable & I_GLOBAL_IE;
            O_WRAP_IRQ <= wrap_flag_r & wrap_irq_enable & I_GLOBAL_IE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RSTN);

    stop_flag_set_a: assert property (det_stop |=> stop_seen_flag_r)
        else $error("stop flag not set after stop condition");

    stop_flag_keep_a: assert property (
        stop_seen_flag_r && !clr_stop |=> stop_seen_flag_r)
        else $error("stop flag lost without a clearing write");

    coll_read_a: assert property (
        I_RD && I_ADDR == SIWM_ADDR_STATUS && two_wire
        |=> O_RDATA[ST_COLL] == ($past(sda_s) ^ $past(I_SHIFT_MSB)))
        else $error("collision bit does not match line and MSB");

    count_load_a: assert property (
        wr_status |=> edge_count_value_r == $past(I_WDATA[3:0]))
        else $error("counter not loaded by status write");

    count_step_a: assert property (
        cnt_tick && !wr_status
        |=> edge_count_value_r == 4'($past(edge_count_value_r) + 4'h1))
        else $error("counter did not step by one");

    toggle_count_a: assert property (
        ext_clock && soft_strobe_bit_r && wr_ctrl && I_WDATA[CT_TC] && !scl_edge
        ##1 !wr_status [*1] |-> edge_count_value_r != $past(edge_count_value_r))
        else $error("toggle strobe did not clock the counter");

    start_irq_a: assert property (
        start_seen_flag_r && start_irq_enable && I_GLOBAL_IE |=> O_START_IRQ)
        else $error("start request not raised");

    wrap_irq_a: assert property (
        O_WRAP_IRQ |-> $past(wrap_flag_r) && $past(wrap_irq_enable))
        else $error("wrap request without flag and enable");

    off_mode_a: assert property (
        wire_mode_select == WM_OFF && !wr_ctrl
        |=> O_SCL_OE == $past(dir_scl) && O_SDA_OUT == $past(port_sda))
        else $error("mode zero pins are not plain port pins");

    detect_off_a: assert property (!two_wire |-> !det_start && !det_stop)
        else $error("line condition detected outside two-wire mode");

    start_hold_a: assert property (
        start_seen_flag_r && two_wire && dir_scl |=> O_SCL_OE && !O_SCL_OUT)
        else $error("SCL not held after start condition");

    wrap_hold_a: assert property (
        wrap_flag_r && hold_mode && dir_scl && !clr_wrap && !wr_ctrl && !wr_pins
        ##1 !clr_wrap |=> O_SCL_OE)
        else $error("SCL not held after counter wrap");

    wrap_set_a: assert property (
        wrap_evt |=> wrap_flag_r && edge_count_value_r == CNT_RST)
        else $error("wrap flag not set on 15 to 0");

    wrap_keep_a: assert property (
        wrap_flag_r && !clr_wrap |=> wrap_flag_r)
        else $error("wrap flag lost without a clearing write");

    wrap_clear_a: assert property (
        clr_wrap && !wrap_evt |=> !wrap_flag_r)
        else $error("wrap flag not cleared by a one");

    start_flag_set_a: assert property (det_start |=> start_seen_flag_r)
        else $error("start flag not set after start condition");

    pullup_off_a: assert property (
        two_wire |=> !O_SDA_PU && !O_SCL_PU)
        else $error("pull-up enabled in two-wire mode");

    sda_pull_a: assert property (
        two_wire && dir_sda && !I_SHIFT_MSB |=> O_SDA_OE && !O_SDA_OUT)
        else $error("SDA not pulled low for a zero MSB");

    start_seen_c: cover property (det_start ##[1:20] clr_start);
    wrap_seen_c: cover property (wrap_evt && hold_mode);
    stop_seen_c: cover property (det_stop && two_wire);
    toggle_seen_c: cover property (toggle_tick);

endmodule : siwm_core

// file: core/siwm_line_det.sv
`timescale 1ns/10ps
module siwm_line_det (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Synchronised line levels.
    input wire logic i_sda,
    input wire logic i_scl,
    input wire logic i_enable,
    // One-cycle events.
    output logic o_start,
    output logic o_stop,
    output logic o_scl_edge
);

    logic sda_prev_r;
    logic scl_prev_r;
    wire scl_high = i_scl & scl_prev_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sda_prev_r <= 1'b1;
            scl_prev_r <= 1'b1;
        end else begin
            sda_prev_r <= i_sda;
            scl_prev_r <= i_scl;
        end
    end

    // Both line changes are qualified by SCL high on two samples, so a
    // data change that races a clock edge is not mistaken for a condition.
    assign o_start = i_enable & scl_high & sda_prev_r & ~i_sda;
    assign o_stop = i_enable & scl_high & ~sda_prev_r & i_sda;
    // The edge detector ignores the wire mode, so no wire mode stops external counting.
    assign o_scl_edge = i_scl ^ scl_prev_r;

endmodule : siwm_line_det

// file: core/siwm_pkg.sv
package siwm_pkg;

    // Register indices on the plain register port.
    localparam logic [1:0] SIWM_ADDR_STATUS = 2'h0;
    localparam logic [1:0] SIWM_ADDR_CONTROL = 2'h1;
    localparam logic [1:0] SIWM_ADDR_PINS = 2'h2;

    // serial_status field positions.
    localparam int ST_START = 7;
    localparam int ST_WRAP = 6;
    localparam int ST_STOP = 5;
    localparam int ST_COLL = 4;
    localparam int ST_CNT_LO = 0;

    // serial_control field positions.
    localparam int CT_SIE = 7;
    localparam int CT_OIE = 6;
    localparam int CT_WM_LO = 4;
    localparam int CT_CS_LO = 2;
    localparam int CT_CLK = 1;
    localparam int CT_TC = 0;

    // Pin port register: port bits low, direction bits high.
    localparam int PN_DO = 0;
    localparam int PN_SDA = 1;
    localparam int PN_SCL = 2;
    localparam int PN_DIR_LO = 4;

    // Reset values.
    localparam logic [5:0] CONTROL_RST = 6'h00;
    localparam logic [7:0] PINS_RST = 8'h00;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [3:0] CNT_MAX = 4'hF;
    localparam logic [7:0] RDATA_RST = 8'h00;

    typedef enum logic [1:0] {
        WM_OFF,
        WM_THREE,
        WM_TWO,
        WM_TWO_HOLD
    } siwm_wire_t;

    typedef enum logic [1:0] {
        CS_SOFT,
        CS_TIMER,
        CS_EXT_POS,
        CS_EXT_NEG
    } siwm_csel_t;

endpackage : siwm_pkg

// file: core/siwm_sync.sv
`timescale 1ns/10ps
module siwm_sync #(
    parameter int W = 2
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    logic [W-1:0] meta_r;

    // The first stage feeds the second stage only. Both stages reset to the
    // idle high level of the pulled-up lines, so no false edge follows reset.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= '1;
            o_sync <= '1;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end

endmodule : siwm_sync

// file: verification/siwm_bus_master.sv
`timescale 1ns/10ps
module siwm_bus_master (
    // Sensed wire levels.
    input wire logic i_sda,
    input wire logic i_scl,
    // Open-drain pull-down enables, high while pulling low.
    output logic o_sda_low,
    output logic o_scl_low
);
    localparam time HALF = 16ns;
    // Counts clock releases that the slave stretched beyond the wait bound.
    int stretch_timeouts = 0;

    initial begin
        o_sda_low = 1'b0;
        o_scl_low = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic start_cond();
        o_sda_low = 1'b1;
        #HALF;
    endtask : start_cond

    // The slave may stretch the clock, so the rising edge waits, but not forever.
    task automatic stop_cond();
        o_scl_low = 1'b1;
        #HALF;
        o_sda_low = 1'b1;
        #HALF;
        o_scl_low = 1'b0;
        for (int i = 0; i < 64 && !i_scl; i++) begin
            #1;
        end
        if (!i_scl) begin
            stretch_timeouts++;
        end
        #HALF;
        o_sda_low = 1'b0;
        #HALF;
    endtask : stop_cond

    task automatic pulse();
        o_scl_low = 1'b1;
        #HALF;
        o_scl_low = 1'b0;
        #HALF;
    endtask : pulse

    task automatic hold_scl(input logic v);
        o_scl_low = v;
        #HALF;
    endtask : hold_scl
endmodule : siwm_bus_master

// file: verification/tb.sv
`timescale 1ns/10ps
module tb;
    import siwm_pkg::*;
    logic I_MCLK, I_RSTN, I_WR, I_RD, I_TIMER_MATCH, I_GLOBAL_IE, I_SHIFT_MSB;
    logic [1:0] I_ADDR;
    logic [7:0] I_WDATA, O_RDATA;
    logic O_SDA_OUT, O_SDA_OE, O_SDA_PU, O_SCL_OUT, O_SCL_OE, O_SCL_PU;
    logic O_DO_OUT, O_DO_OE, O_DO_PU, O_START_IRQ, O_WRAP_IRQ, m_sda_low, m_scl_low;
    wire sda_w, scl_w;
    int errors, samples_checked;

    // Both lines carry a pull-up; any driver enabled with a low value wins.
    assign sda_w = !(O_SDA_OE && !O_SDA_OUT) && !m_sda_low;
    assign scl_w = !(O_SCL_OE && !O_SCL_OUT) && !m_scl_low;

    siwm_core uut (.I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
        .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_TIMER_MATCH(I_TIMER_MATCH),
        .I_GLOBAL_IE(I_GLOBAL_IE), .I_SHIFT_MSB(I_SHIFT_MSB), .I_SDA_PIN(sda_w),
        .O_SDA_OUT(O_SDA_OUT), .O_SDA_OE(O_SDA_OE), .O_SDA_PU(O_SDA_PU), .I_SCL_PIN(scl_w),
        .O_SCL_OUT(O_SCL_OUT), .O_SCL_OE(O_SCL_OE), .O_SCL_PU(O_SCL_PU),
        .O_DO_OUT(O_DO_OUT), .O_DO_OE(O_DO_OE), .O_DO_PU(O_DO_PU),
        .O_START_IRQ(O_START_IRQ), .O_WRAP_IRQ(O_WRAP_IRQ));

    siwm_bus_master m (.i_sda(sda_w), .i_scl(scl_w), .o_sda_low(m_sda_low),
        .o_scl_low(m_scl_low));

    initial begin
        I_MCLK = 1'b0;
        forever #2 I_MCLK = ~I_MCLK;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge I_MCLK);
        #1;
    endtask : cyc

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge I_MCLK);
        I_ADDR <= a;
        I_WDATA <= d;
        I_WR <= 1'b1;
        @(posedge I_MCLK);
        I_WR <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rchk(input string n, input logic [1:0] a, input logic [7:0] mask,
        input logic [7:0] exp);
        @(posedge I_MCLK);
        I_ADDR <= a;
        I_RD <= 1'b1;
        @(posedge I_MCLK);
        I_RD <= 1'b0;
        #1;
        chk(n, O_RDATA & mask, exp);
    endtask : rchk

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rchk("status", SIWM_ADDR_STATUS, 8'hEF, 8'h00);
        rchk("control", SIWM_ADDR_CONTROL, 8'hFF, 8'h00);
        rchk("pins", SIWM_ADDR_PINS, 8'hFF, 8'h00);
        wr(SIWM_ADDR_CONTROL, 8'hFF);
        rchk("control", SIWM_ADDR_CONTROL, 8'hFF, 8'hFC);
        rchk("pins", SIWM_ADDR_PINS, 8'hFF, 8'h04);
        wr(SIWM_ADDR_PINS, 8'h88);
        rchk("pins", SIWM_ADDR_PINS, 8'hFF, 8'h88);
        wr(2'h3, 8'hFF);
        rchk("unmapped", 2'h3, 8'hFF, 8'h00);
        wr(SIWM_ADDR_CONTROL, 8'h00);
        wr(SIWM_ADDR_PINS, 8'h00);
        rchk("count", SIWM_ADDR_STATUS, 8'h0F, 8'h01);
        $display("test regs done");
    endtask : t_regs

    task automatic t_count();
        wr(SIWM_ADDR_STATUS, 8'h0E);
        rchk("count", SIWM_ADDR_STATUS, 8'h4F, 8'h0E);
        wr(SIWM_ADDR_CONTROL, 8'h02);
        wr(SIWM_ADDR_CONTROL, 8'h42);
        rchk("wrap", SIWM_ADDR_STATUS, 8'h4F, 8'h40);
        chk("wrap_irq", {7'h00, O_WRAP_IRQ}, 8'h01);
        I_GLOBAL_IE <= 1'b0;
        cyc(2);
        chk("wrap_irq", {7'h00, O_WRAP_IRQ}, 8'h00);
        I_GLOBAL_IE <= 1'b1;
        wr(SIWM_ADDR_STATUS, 8'h03);
        rchk("wrap", SIWM_ADDR_STATUS, 8'h4F, 8'h43);
        wr(SIWM_ADDR_STATUS, 8'h43);
        rchk("wrap", SIWM_ADDR_STATUS, 8'h4F, 8'h03);
        chk("wrap_irq", {7'h00, O_WRAP_IRQ}, 8'h00);
        wr(SIWM_ADDR_CONTROL, 8'h04);
        for (int i = 0; i < 3; i++) begin
            @(posedge I_MCLK);
            I_TIMER_MATCH <= 1'b1;
            @(posedge I_MCLK);
            I_TIMER_MATCH <= 1'b0;
        end
        rchk("count", SIWM_ADDR_STATUS, 8'h0F, 8'h06);
        $display("test count done");
    endtask : t_count

    task automatic t_ext();
        wr(SIWM_ADDR_CONTROL, 8'h08);
        m.pulse();
        m.pulse();
        cyc(8);
        rchk("count", SIWM_ADDR_STATUS, 8'h0F, 8'h0A);
        wr(SIWM_ADDR_CONTROL, 8'h0A);
        wr(SIWM_ADDR_CONTROL, 8'h0B);
        m.pulse();
        cyc(8);
        rchk("count", SIWM_ADDR_STATUS, 8'h0F, 8'h0B);
        rchk("pins", SIWM_ADDR_PINS, 8'hFF, 8'h04);
        wr(SIWM_ADDR_CONTROL, 8'h18);
        m.pulse();
        cyc(8);
        rchk("count", SIWM_ADDR_STATUS, 8'h0F, 8'h0D);
        wr(SIWM_ADDR_CONTROL, 8'h00);
        wr(SIWM_ADDR_PINS, 8'h00);
        $display("test ext done");
    endtask : t_ext

    task automatic t_pins();
        wr(SIWM_ADDR_PINS, 8'h11);
        cyc(2);
        chk("do", {5'h00, O_DO_OUT, O_DO_OE, O_DO_PU}, 8'h06);
        wr(SIWM_ADDR_PINS, 8'h01);
        cyc(2);
        chk("do", {5'h00, O_DO_OUT, O_DO_OE, O_DO_PU}, 8'h05);
        wr(SIWM_ADDR_CONTROL, 8'h10);
        wr(SIWM_ADDR_PINS, 8'h10);
        cyc(2);
        chk("do", {5'h00, O_DO_OUT, O_DO_OE, O_DO_PU}, 8'h06);
        wr(SIWM_ADDR_CONTROL, 8'h00);
        cyc(2);
        chk("do", {5'h00, O_DO_OUT, O_DO_OE, O_DO_PU}, 8'h02);
        wr(SIWM_ADDR_PINS, 8'h06);
        cyc(2);
        chk("pullups", {6'h00, O_SDA_PU, O_SCL_PU}, 8'h03);
        wr(SIWM_ADDR_CONTROL, 8'h20);
        cyc(2);
        chk("pullups", {6'h00, O_SDA_PU, O_SCL_PU}, 8'h00);
        wr(SIWM_ADDR_CONTROL, 8'h00);
        wr(SIWM_ADDR_PINS, 8'h00);
        $display("test pins done");
    endtask : t_pins

    task automatic t_two();
        m.start_cond();
        m.stop_cond();
        cyc(8);
        rchk("flags", SIWM_ADDR_STATUS, 8'hE0, 8'h00);
        wr(SIWM_ADDR_PINS, 8'h66);
        wr(SIWM_ADDR_CONTROL, 8'hA0);
        cyc(2);
        chk("oe", {6'h00, O_SDA_OE, O_SCL_OE}, 8'h00);
        m.start_cond();
        cyc(8);
        rchk("start", SIWM_ADDR_STATUS, 8'hF0, 8'h90);
        chk("scl_hold", {7'h00, O_SCL_OE}, 8'h01);
        chk("start_irq", {7'h00, O_START_IRQ}, 8'h01);
        wr(SIWM_ADDR_STATUS, 8'h80);
        cyc(3);
        chk("scl_hold", {7'h00, O_SCL_OE}, 8'h00);
        m.stop_cond();
        cyc(8);
        rchk("stop", SIWM_ADDR_STATUS, 8'hF0, 8'h20);
        chk("irqs", {6'h00, O_START_IRQ, O_WRAP_IRQ}, 8'h00);
        wr(SIWM_ADDR_STATUS, 8'h20);
        rchk("stop", SIWM_ADDR_STATUS, 8'hE0, 8'h00);
        // Data changes only while the clock is low, so no start or stop appears.
        m.hold_scl(1'b1);
        I_SHIFT_MSB <= 1'b0;
        cyc(2);
        chk("sda", {6'h00, O_SDA_OE, O_SDA_OUT}, 8'h02);
        I_SHIFT_MSB <= 1'b1;
        wr(SIWM_ADDR_PINS, 8'h64);
        cyc(2);
        chk("sda", {6'h00, O_SDA_OE, O_SDA_OUT}, 8'h02);
        wr(SIWM_ADDR_PINS, 8'h62);
        cyc(2);
        chk("scl", {6'h00, O_SCL_OE, O_SCL_OUT}, 8'h02);
        wr(SIWM_ADDR_PINS, 8'h66);
        m.hold_scl(1'b0);
        wr(SIWM_ADDR_STATUS, 8'h0F);
        wr(SIWM_ADDR_CONTROL, 8'h32);
        cyc(3);
        chk("wrap_hold", {7'h00, O_SCL_OE}, 8'h01);
        wr(SIWM_ADDR_STATUS, 8'h4F);
        cyc(3);
        chk("wrap_release", {7'h00, O_SCL_OE}, 8'h00);
        wr(SIWM_ADDR_CONTROL, 8'h22);
        cyc(3);
        chk("wrap_hold", {7'h00, O_SCL_OE}, 8'h00);
        wr(SIWM_ADDR_STATUS, 8'h40);
        wr(SIWM_ADDR_CONTROL, 8'h00);
        wr(SIWM_ADDR_PINS, 8'h00);
        chk("stretch", 8'(m.stretch_timeouts), 8'h00);
        $display("test two wire done");
    endtask : t_two

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        errors++;
        results();
    end

    initial begin
        errors = 0;
        samples_checked = 0;
        I_RSTN = 1'b0;
        I_WR = 1'b0;
        I_RD = 1'b0;
        I_ADDR = 2'h0;
        I_WDATA = 8'h00;
        I_TIMER_MATCH = 1'b0;
        I_GLOBAL_IE = 1'b1;
        I_SHIFT_MSB = 1'b1;
        repeat (6) @(posedge I_MCLK);
        I_RSTN <= 1'b1;
        cyc(3);
        t_regs();
        t_count();
        t_ext();
        t_pins();
        t_two();
        results();
    end
endmodule : tb
